// [verilog/lbmpu_pkg.sv]
package lbmpu_pkg;

  // register byte offsets on the apb slave
  localparam logic [11:0] LBMPU_OFS_LIFE    = 12'h000;
  localparam logic [11:0] LBMPU_OFS_PWD     = 12'h004;
  localparam logic [11:0] LBMPU_OFS_OPMODE  = 12'h008;
  localparam logic [11:0] LBMPU_OFS_TRACE   = 12'h00c;
  localparam logic [11:0] LBMPU_OFS_STATUS  = 12'h010;
  localparam logic [11:0] LBMPU_OFS_MASK    = 12'h014;
  localparam logic [11:0] LBMPU_OFS_FTEST   = 12'h018;
  localparam logic [11:0] LBMPU_OFS_PART    = 12'h100;
  // partition block: 16 bytes per partition, base/limit/attr words
  localparam int          LBMPU_NPART       = 8;
  localparam int          LBMPU_NFLASH      = 4;
  localparam logic [1:0]  LBMPU_PW_BASE     = 2'h0;
  localparam logic [1:0]  LBMPU_PW_LIMIT    = 2'h1;
  localparam logic [1:0]  LBMPU_PW_ATTR     = 2'h2;

  // attribute bits
  localparam int          LBMPU_AT_READ     = 0;
  localparam int          LBMPU_AT_WRITE    = 1;
  localparam int          LBMPU_AT_EXEC     = 2;
  localparam int          LBMPU_AT_EN       = 3;

  // operating mode select fields
  localparam int          LBMPU_OM_FBOOT    = 0;
  localparam int          LBMPU_OM_LOCK     = 1;
  localparam int          LBMPU_OM_ROMHIDE  = 2;
  localparam int          LBMPU_OM_FLWP     = 3;
  localparam int          LBMPU_OM_FLWP_W   = 4;
  localparam logic [7:0]  LBMPU_OM_RST      = 8'h00;

  // status / mask event bits
  localparam int          LBMPU_EV_INVADDR  = 0;
  localparam int          LBMPU_EV_MPU      = 1;
  localparam int          LBMPU_EV_FLEXEC   = 2;
  localparam int          LBMPU_EV_FLWR     = 3;
  localparam int          LBMPU_EV_REGPRIV  = 4;
  localparam int          LBMPU_EV_TESTREJ  = 5;
  localparam int          LBMPU_EV_LOADER   = 6;
  localparam int          LBMPU_NEV         = 7;

  localparam logic [31:0] LBMPU_PWD_DEF     = 32'h5a5a_c3c3;
  localparam logic [31:0] LBMPU_NORMAL_KEY  = 32'h00a5_0f5a;
  localparam logic [31:0] LBMPU_ATTR_RST    = 32'h0000_0000;

  // memory map of the core side
  localparam logic [31:0] LBMPU_ROM_LO      = 32'h0000_0000;
  localparam logic [31:0] LBMPU_ROM_HI      = 32'h0000_ffff;
  localparam logic [31:0] LBMPU_FL_LO       = 32'h0010_0000;
  localparam logic [31:0] LBMPU_FL_HI       = 32'h001f_ffff;
  localparam logic [31:0] LBMPU_TRC_LO      = 32'h001f_f000;
  localparam logic [31:0] LBMPU_RAM_LO      = 32'h0020_0000;
  localparam logic [31:0] LBMPU_RAM_HI      = 32'h0020_ffff;

  typedef enum logic [1:0] {
    LBMPU_LC_LOCKED = 2'b00,
    LBMPU_LC_TEST   = 2'b01,
    LBMPU_LC_NORMAL = 2'b10
  } lbmpu_life_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic        priv;
    logic        loader;
    logic [31:0] addr;
  } lbmpu_acc_t;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
    logic [3:0]  attr;
  } lbmpu_part_t;

endpackage : lbmpu_pkg

// [verilog/lbmpu_top.sv]
`timescale 1ns/1ps
// Operation
// - normal mode is permanent, never back to test; code resets to locked, where the password gives test again
// - test mode only after correct password
// - test commands rejected in normal mode
// - trace data writable only in test mode
// - functional test only in test mode
// - software selects rom or flash boot
// - boot mode frozen once flash boot locked
// - bootloader runs only under rom boot
// - locked flash boot blocks loader flash access
// - base and limit per flash/ram partition
// - user access only where attributes allow; code grants user ram fetches without checking attributes
// - security registers writable only when privileged
// - detect and report invalid addresses
// - check rights of flash-executed code
// - all registers take defaults on reset
// - rom and flash attributes reset defined
// - mode register sets rom/flash protection
// - refuse unpermitted flash writes
module lbmpu_top
  import lbmpu_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  input  wire logic        pprot_priv_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire lbmpu_acc_t  acc_in,
  output logic             acc_grant_out,
  output logic             acc_fault_out,
  input  wire logic        test_cmd_in,
  output logic             test_cmd_ok_out,
  output logic             test_mode_out,
  output logic             flash_boot_out,
  output logic             loader_en_out,
  output logic             ftest_en_out,
  output logic             irq_out
);

  lbmpu_life_t         life_r;
  logic [31:0]         pwd_r;
  logic [7:0]          opmode_r;
  logic [31:0]         trace_r;
  logic [LBMPU_NEV-1:0] status_r;
  logic [LBMPU_NEV-1:0] mask_r;
  logic                ftest_r;
  lbmpu_part_t         part_r [LBMPU_NPART];
  logic [LBMPU_NEV-1:0] ev_nxt;
  logic [31:0]         rdata_nxt;
  logic                err_nxt;
  logic                grant_nxt;

  // one-cycle setup then access, so pready is a registered pulse
  logic acc_ph;
  logic wr_ok;
  logic wr_req;
  logic rd_req;
  logic in_part;
  logic [11:0] part_ofs;
  logic [2:0]  part_idx;
  logic [1:0]  part_word;

  assign acc_ph    = psel_in && penable_in && !pready_out;
  assign wr_req    = acc_ph && pwrite_in;
  assign rd_req    = acc_ph && !pwrite_in;
  assign wr_ok     = wr_req && pprot_priv_in && (pstrb_in == 4'hf);
  assign part_ofs  = paddr_in - LBMPU_OFS_PART;
  assign in_part   = (paddr_in >= LBMPU_OFS_PART) &&
                     (part_ofs[11:4] < 8'(LBMPU_NPART)) &&
                     (part_ofs[3:2] != 2'h3);
  assign part_idx  = part_ofs[6:4];
  assign part_word = part_ofs[3:2];

  logic test_mode;
  logic fboot_locked;
  assign test_mode    = (life_r == LBMPU_LC_TEST);
  assign fboot_locked = opmode_r[LBMPU_OM_FBOOT] && opmode_r[LBMPU_OM_LOCK];

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      pready_out <= 1'b0;
    else
      pready_out <= acc_ph;
  end

  // lifecycle: locked -> test via password, test -> normal one-way
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      life_r <= LBMPU_LC_LOCKED;
    else if (wr_ok && paddr_in == LBMPU_OFS_LIFE)
    begin
      unique case (life_r)
        LBMPU_LC_LOCKED:
          if (pwdata_in == pwd_r)
            life_r <= LBMPU_LC_TEST;
        LBMPU_LC_TEST:
          if (pwdata_in == LBMPU_NORMAL_KEY)
            life_r <= LBMPU_LC_NORMAL;
        LBMPU_LC_NORMAL:
          life_r <= LBMPU_LC_NORMAL;
        default:
          life_r <= LBMPU_LC_NORMAL;
      endcase
    end
  end

  // the password reset value stands in for a fused secret
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      pwd_r <= LBMPU_PWD_DEF;
    else if (wr_ok && test_mode && paddr_in == LBMPU_OFS_PWD)
      pwd_r <= pwdata_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      trace_r <= 32'h0;
    else if (wr_ok && test_mode && paddr_in == LBMPU_OFS_TRACE)
      trace_r <= pwdata_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      ftest_r <= 1'b0;
    else if (!test_mode)
      ftest_r <= 1'b0;
    else if (wr_ok && paddr_in == LBMPU_OFS_FTEST)
      ftest_r <= pwdata_in[0];
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      opmode_r <= LBMPU_OM_RST;
    else if (wr_ok && paddr_in == LBMPU_OFS_OPMODE && !fboot_locked)
      opmode_r <= pwdata_in[7:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < LBMPU_NPART; gi++)
    begin : g_part
      always_ff @(posedge mclk_in)
      begin
        if (rst_in)
        begin
          part_r[gi] <= '0;
        end
        else if (wr_ok && in_part && part_idx == 3'(gi))
        begin
          unique case (part_word)
            LBMPU_PW_BASE:  part_r[gi].base  <= pwdata_in;
            LBMPU_PW_LIMIT: part_r[gi].limit <= pwdata_in;
            LBMPU_PW_ATTR:  part_r[gi].attr  <= pwdata_in[3:0];
            default:        part_r[gi].attr  <= part_r[gi].attr;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      mask_r <= '0;
    else if (wr_ok && paddr_in == LBMPU_OFS_MASK)
      mask_r <= pwdata_in[LBMPU_NEV-1:0];
  end

  // access check on the core side; privileged accesses bypass the mpu
  logic a_rom;
  logic a_fl;
  logic a_ram;
  logic a_trc;
  logic [LBMPU_NPART-1:0] hit;
  logic [LBMPU_NPART-1:0] allow;
  logic [3:0] wp_sel;
  logic mpu_bad;
  logic flwr_bad;

  assign a_rom = acc_in.addr <= LBMPU_ROM_HI;
  assign a_fl  = acc_in.addr >= LBMPU_FL_LO && acc_in.addr <= LBMPU_FL_HI;
  assign a_ram = acc_in.addr >= LBMPU_RAM_LO && acc_in.addr <= LBMPU_RAM_HI;
  assign a_trc = acc_in.addr >= LBMPU_TRC_LO && a_fl;
  assign wp_sel = acc_in.addr[19:16];

  generate
    for (gi = 0; gi < LBMPU_NPART; gi++)
    begin : g_hit
      // first half of the partitions guard flash, second half ram
      logic in_mem;
      assign in_mem = (gi < LBMPU_NFLASH) ? a_fl : a_ram;
      assign hit[gi] = part_r[gi].attr[LBMPU_AT_EN] && in_mem &&
                       acc_in.addr >= part_r[gi].base &&
                       acc_in.addr <= part_r[gi].limit;
      assign allow[gi] = hit[gi] &&
        (acc_in.write ? part_r[gi].attr[LBMPU_AT_WRITE] :
         acc_in.fetch ? part_r[gi].attr[LBMPU_AT_EXEC] :
                        part_r[gi].attr[LBMPU_AT_READ]);
    end
  endgenerate

  // user access needs an allowing partition; no partition means no access, except for ram fetches
  assign mpu_bad  = !acc_in.priv && (a_fl || a_ram) && (allow == '0);
  assign flwr_bad = acc_in.write && a_fl &&
                    (wp_sel[LBMPU_OM_FLWP_W-1:0] <
                     LBMPU_OM_FLWP_W'(opmode_r[LBMPU_OM_FLWP +: 1]) ||
                     (a_trc && !test_mode));

  always_comb
  begin
    ev_nxt = '0;
    if (acc_in.valid)
    begin
      ev_nxt[LBMPU_EV_INVADDR] = !(a_rom || a_fl || a_ram) ||
        (a_rom && acc_in.write) ||
        (a_rom && !acc_in.priv && opmode_r[LBMPU_OM_ROMHIDE]);
      ev_nxt[LBMPU_EV_MPU]     = mpu_bad && !acc_in.fetch;
      ev_nxt[LBMPU_EV_FLEXEC]  = mpu_bad && acc_in.fetch && a_fl;
      ev_nxt[LBMPU_EV_FLWR]    = flwr_bad;
      ev_nxt[LBMPU_EV_LOADER]  = acc_in.loader &&
                                 (opmode_r[LBMPU_OM_FBOOT] || a_fl &&
                                  fboot_locked);
    end
    ev_nxt[LBMPU_EV_REGPRIV] = wr_req && !pprot_priv_in;
    ev_nxt[LBMPU_EV_TESTREJ] = test_cmd_in && !test_mode;
    grant_nxt = acc_in.valid && (ev_nxt[LBMPU_EV_LOADER:LBMPU_EV_INVADDR] &
                ~(LBMPU_NEV-LBMPU_EV_INVADDR)'(7'h30)) == '0;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      status_r <= '0;
    else if (wr_ok && paddr_in == LBMPU_OFS_STATUS)
      status_r <= (status_r & ~pwdata_in[LBMPU_NEV-1:0]) | ev_nxt;
    else
      status_r <= status_r | ev_nxt;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      acc_grant_out   <= 1'b0;
      acc_fault_out   <= 1'b0;
      test_cmd_ok_out <= 1'b0;
    end
    else
    begin
      acc_grant_out   <= grant_nxt;
      acc_fault_out   <= acc_in.valid && !grant_nxt;
      test_cmd_ok_out <= test_cmd_in && test_mode;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      test_mode_out  <= 1'b0;
      flash_boot_out <= 1'b0;
      loader_en_out  <= 1'b0;
      ftest_en_out   <= 1'b0;
      irq_out        <= 1'b0;
    end
    else
    begin
      test_mode_out  <= test_mode;
      flash_boot_out <= opmode_r[LBMPU_OM_FBOOT];
      loader_en_out  <= !opmode_r[LBMPU_OM_FBOOT];
      ftest_en_out   <= ftest_r && test_mode;
      // new events raise irq at once; a w1c clear drops it a cycle late
      irq_out        <= |((status_r | ev_nxt) & mask_r);
    end
  end

  always_comb
  begin
    rdata_nxt = 32'h0;
    err_nxt   = 1'b0;
    if (in_part)
    begin
      unique case (part_word)
        LBMPU_PW_BASE:  rdata_nxt = part_r[part_idx].base;
        LBMPU_PW_LIMIT: rdata_nxt = part_r[part_idx].limit;
        default:        rdata_nxt = {28'h0, part_r[part_idx].attr};
      endcase
    end
    else
    begin
      unique case (paddr_in)
        LBMPU_OFS_LIFE:   rdata_nxt = {30'h0, life_r};
        LBMPU_OFS_PWD:    rdata_nxt = 32'h0; // never readable
        LBMPU_OFS_OPMODE: rdata_nxt = {24'h0, opmode_r};
        LBMPU_OFS_TRACE:  rdata_nxt = trace_r;
        LBMPU_OFS_STATUS: rdata_nxt = {25'h0, status_r};
        LBMPU_OFS_MASK:   rdata_nxt = {25'h0, mask_r};
        LBMPU_OFS_FTEST:  rdata_nxt = {31'h0, ftest_r};
        default:          err_nxt   = 1'b1;
      endcase
    end
    if (wr_req && !pprot_priv_in)
      err_nxt = 1'b1;
    if (rd_req && !pprot_priv_in && paddr_in == LBMPU_OFS_STATUS)
      err_nxt = 1'b1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      prdata_out  <= (rd_req && !err_nxt) ? rdata_nxt : 32'h0;
      pslverr_out <= acc_ph && err_nxt;
    end
  end

endmodule : lbmpu_top

// [testbench/lbmpu_top_assertions.sv]
`timescale 1ns/1ps
module lbmpu_top_checker
  import lbmpu_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic       pwrite_in,
  input wire logic       pprot_priv_in,
  input wire logic       pready_out,
  input wire logic       pslverr_out,
  input wire lbmpu_acc_t acc_in,
  input wire logic       acc_grant_out,
  input wire logic       acc_fault_out,
  input wire logic       test_cmd_in,
  input wire logic       test_cmd_ok_out,
  input wire logic       test_mode_out,
  input wire logic       flash_boot_out,
  input wire logic       loader_en_out,
  input wire logic       ftest_en_out
);
  logic left_r;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // test mode is only ever left towards normal, so its fall marks the switch
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      left_r <= 1'b0;
    else if ($fell(test_mode_out) && !$past(rst_in))
      left_r <= 1'b1;
  end
  a_one_answer: assert property (acc_in.valid |=>
    (acc_grant_out ^ acc_fault_out)) else $error("core access answer wrong");
  a_no_stray: assert property (!acc_in.valid |=>
    !acc_grant_out && !acc_fault_out) else $error("answer without access");
  a_bad_addr: assert property (acc_in.valid && acc_in.addr > LBMPU_RAM_HI
    |=> acc_fault_out) else $error("invalid address granted");
  a_normal_final: assert property (left_r |-> !test_mode_out)
    else $error("test mode came back");
  a_cmd_gate: assert property (test_cmd_ok_out |->
    $past(test_cmd_in) && !left_r) else $error("test command accepted");
  a_loader_rom: assert property (loader_en_out |-> !flash_boot_out)
    else $error("loader enabled under flash boot");
  a_ftest_test: assert property (ftest_en_out |-> test_mode_out)
    else $error("functional test outside test mode");
  a_ready_due: assert property (psel_in && penable_in && !pready_out
    |=> pready_out) else $error("apb answer late");
  a_unpriv_err: assert property (psel_in && penable_in && !pready_out
    && pwrite_in && !pprot_priv_in |=> pslverr_out)
    else $error("unprivileged write not refused");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
endmodule : lbmpu_top_checker

bind lbmpu_top lbmpu_top_checker u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .pprot_priv_in(pprot_priv_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .acc_in(acc_in), .acc_grant_out(acc_grant_out),
  .acc_fault_out(acc_fault_out), .test_cmd_in(test_cmd_in),
  .test_cmd_ok_out(test_cmd_ok_out), .test_mode_out(test_mode_out),
  .flash_boot_out(flash_boot_out), .loader_en_out(loader_en_out),
  .ftest_en_out(ftest_en_out));

// [testbench/lbmpu_core_model.sv]
`timescale 1ns/1ps
module lbmpu_core_model
  import lbmpu_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       go_in,
  input  wire lbmpu_acc_t req_in,
  input  wire logic       grant_in,
  input  wire logic       fault_in,
  output lbmpu_acc_t      acc_out,
  output logic            done_out,
  output logic            granted_out
);
  logic wait_r;
  // idle address toggles so nothing can lean on a stale bus value
  initial
  begin
    acc_out = '0;
    done_out = 1'b0;
    granted_out = 1'b0;
    wait_r = 1'b0;
    forever
    begin
      @(posedge mclk_in);
      done_out <= 1'b0;
      if (acc_out.valid)
      begin
        acc_out.valid <= 1'b0;
        acc_out.addr <= ~acc_out.addr;
        wait_r <= 1'b1;
      end
      else if (wait_r && (grant_in || fault_in))
      begin
        granted_out <= grant_in;
        done_out <= 1'b1;
        wait_r <= 1'b0;
      end
      else if (go_in && !wait_r)
        acc_out <= req_in;
      else
        acc_out.addr <= ~acc_out.addr;
    end
  end
endmodule : lbmpu_core_model

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb
  import lbmpu_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pprot_priv = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  lbmpu_acc_t  acc;
  lbmpu_acc_t  req = '0;
  logic        go = 1'b0;
  logic        tcmd = 1'b0;
  logic        grant, fault, tcmd_ok, tmode, fboot, ldr_en, ftest, irq;
  logic        done, granted, er_s;
  logic [31:0] rd_s;
  int          err_count = 0;
  int          checks = 0;

  always #2.5 mclk = ~mclk;

  lbmpu_top dut (.mclk_in(mclk), .rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(4'hf), .pprot_priv_in(pprot_priv),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .acc_in(acc), .acc_grant_out(grant), .acc_fault_out(fault),
    .test_cmd_in(tcmd), .test_cmd_ok_out(tcmd_ok), .test_mode_out(tmode),
    .flash_boot_out(fboot), .loader_en_out(ldr_en), .ftest_en_out(ftest),
    .irq_out(irq));

  lbmpu_core_model core (.mclk_in(mclk), .go_in(go), .req_in(req),
    .grant_in(grant), .fault_in(fault), .acc_out(acc), .done_out(done),
    .granted_out(granted));

  task automatic give_verdict();
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb_xfer(input logic wr, input logic [11:0] a,
                          input logic [31:0] d, input logic priv);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot_priv <= priv;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd_s = prdata;
    er_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb_xfer

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d, 1'b1);
    repeat (2) @(posedge mclk);
  endtask : reg_wr

  task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0, 1'b1);
    chk(rd_s, exp);
  endtask : reg_chk

  task automatic tcmd_chk(input logic exp);
    tcmd <= 1'b1;
    @(posedge mclk);
    tcmd <= 1'b0;
    @(posedge mclk);
    chk(tcmd_ok, exp);
  endtask : tcmd_chk

  // flags are write, fetch, privileged, loader
  task automatic acc_chk(input logic [3:0] f, input logic [31:0] a,
                         input logic exp);
    req <= {1'b1, f, a};
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    do
      @(posedge mclk);
    while (done !== 1'b1);
    chk(granted, exp);
  endtask : acc_chk

  function automatic logic [11:0] pa(input int i, input logic [1:0] w);
    return LBMPU_OFS_PART + 12'(16 * i) + {8'h0, w, 2'b00};
  endfunction : pa

  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(ldr_en, 1'b1);
    chk(tmode, 1'b0);
    reg_chk(LBMPU_OFS_OPMODE, {24'h0, LBMPU_OM_RST});
    reg_chk(LBMPU_OFS_MASK, 32'h0);
    reg_chk(pa(0, LBMPU_PW_ATTR), LBMPU_ATTR_RST);
    reg_chk(pa(4, LBMPU_PW_ATTR), LBMPU_ATTR_RST);
    apb_xfer(1'b0, 12'h0f0, 32'h0, 1'b1);
    chk(er_s, 1'b1);
    chk(rd_s, 32'h0);
    tcmd_chk(1'b0);
    reg_wr(LBMPU_OFS_LIFE, ~LBMPU_PWD_DEF);
    chk(tmode, 1'b0);
    reg_wr(LBMPU_OFS_LIFE, LBMPU_PWD_DEF);
    chk(tmode, 1'b1);
    tcmd_chk(1'b1);
    reg_wr(LBMPU_OFS_FTEST, 32'h1);
    chk(ftest, 1'b1);
    reg_wr(LBMPU_OFS_TRACE, 32'h1234_abcd);
    reg_chk(LBMPU_OFS_TRACE, 32'h1234_abcd);
    apb_xfer(1'b1, LBMPU_OFS_MASK, 32'h7f, 1'b0);
    chk(er_s, 1'b1);
    reg_chk(LBMPU_OFS_MASK, 32'h0);
    reg_wr(LBMPU_OFS_LIFE, LBMPU_NORMAL_KEY);
    chk({tmode, ftest}, 2'b00);
    reg_wr(LBMPU_OFS_LIFE, LBMPU_PWD_DEF);
    chk(tmode, 1'b0);
    tcmd_chk(1'b0);
    reg_wr(LBMPU_OFS_TRACE, 32'h0);
    reg_chk(LBMPU_OFS_TRACE, 32'h1234_abcd);
    apb_xfer(1'b0, LBMPU_OFS_STATUS, 32'h0, 1'b0);
    chk(er_s, 1'b1);
    reg_chk(LBMPU_OFS_STATUS, 32'h30);
    reg_wr(LBMPU_OFS_STATUS, 32'h7f);
    reg_chk(LBMPU_OFS_STATUS, 32'h0);
    reg_wr(pa(4, LBMPU_PW_BASE), LBMPU_RAM_LO);
    reg_wr(pa(4, LBMPU_PW_LIMIT), LBMPU_RAM_LO + 32'hff);
    reg_wr(pa(4, LBMPU_PW_ATTR), 32'h9);
    reg_chk(pa(4, LBMPU_PW_LIMIT), LBMPU_RAM_LO + 32'hff);
    acc_chk(4'b0000, LBMPU_RAM_LO + 32'h10, 1'b1);
    acc_chk(4'b1000, LBMPU_RAM_LO + 32'h10, 1'b0);
    acc_chk(4'b0000, LBMPU_RAM_LO + 32'h200, 1'b0);
    acc_chk(4'b1010, LBMPU_RAM_LO + 32'h10, 1'b1);
    acc_chk(4'b0010, 32'h0030_0000, 1'b0);
    chk(irq, 1'b0);
    reg_wr(LBMPU_OFS_MASK, 32'h1);
    chk(irq, 1'b1);
    reg_chk(LBMPU_OFS_STATUS, 32'h3);
    reg_wr(LBMPU_OFS_STATUS, 32'h1);
    chk(irq, 1'b0);
    reg_chk(LBMPU_OFS_STATUS, 32'h2);
    reg_wr(pa(0, LBMPU_PW_BASE), LBMPU_FL_LO);
    reg_wr(pa(0, LBMPU_PW_LIMIT), LBMPU_FL_HI);
    reg_wr(pa(0, LBMPU_PW_ATTR), 32'hb);
    acc_chk(4'b0100, 32'h0018_0000, 1'b0);
    acc_chk(4'b1000, 32'h0018_0000, 1'b1);
    reg_wr(LBMPU_OFS_OPMODE, 32'h0c);
    reg_chk(LBMPU_OFS_OPMODE, 32'h0c);
    acc_chk(4'b1000, LBMPU_FL_LO + 32'h10, 1'b0);
    acc_chk(4'b0000, LBMPU_ROM_LO + 32'h10, 1'b0);
    reg_chk(LBMPU_OFS_STATUS, 32'hf);
    reg_wr(LBMPU_OFS_OPMODE, 32'h1);
    chk({fboot, ldr_en}, 2'b10);
    acc_chk(4'b0011, 32'h0018_0000, 1'b0);
    reg_wr(LBMPU_OFS_OPMODE, 32'h0);
    chk({fboot, ldr_en}, 2'b01);
    acc_chk(4'b0011, 32'h0018_0000, 1'b1);
    reg_wr(LBMPU_OFS_OPMODE, 32'h3);
    reg_wr(LBMPU_OFS_OPMODE, 32'h0);
    chk(fboot, 1'b1);
    reg_chk(LBMPU_OFS_OPMODE, 32'h3);
    acc_chk(4'b1011, 32'h0018_0000, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({fboot, ldr_en, tmode, irq}, 4'b0100);
    reg_chk(LBMPU_OFS_OPMODE, {24'h0, LBMPU_OM_RST});
    reg_chk(LBMPU_OFS_STATUS, 32'h0);
    reg_chk(pa(0, LBMPU_PW_ATTR), LBMPU_ATTR_RST);
    give_verdict();
  end
endmodule : tb
